// ==== rtl/fsp_pkg.sv ====
// Purpose: shared constants and types of the fault shutdown link
// Assumes: 20 MHz system clock on both ends
// Notes:   fault line is open drain, low means fault
package fsp_pkg;
  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_HZ        = 20000000;
  localparam int SYNC_HZ       = 500000;
  localparam int SYNC_HALF_CYC = CLK_HZ / SYNC_HZ / 2;
  localparam int RETRY_MS      = 130;
  localparam int RETRY_CYC     = CLK_HZ / 1000 * RETRY_MS;
  localparam int PHASE_STEPS   = 16;
  localparam int PHASE_W       = 4;
  localparam int CNT_W         = 8;
  localparam int RETRY_W       = 22;

  // ****************************************************************
  // protection flags, active low
  // ****************************************************************
  localparam int FLAG_W          = 7;
  localparam int FLAG_HEAT_WARN  = 0;
  localparam int FLAG_PWR_GOOD   = 1;
  localparam int FLAG_RAMP       = 2;
  localparam int FLAG_DIE_HEAT   = 3;
  localparam int FLAG_CUR_LIMIT  = 4;
  localparam int FLAG_OUT_LOW    = 5;
  localparam int FLAG_OUT_HIGH   = 6;
  localparam logic [6:0] FLAGS_RESET = 7'h7F;

  // ****************************************************************
  // manager registers
  // ****************************************************************
  localparam int ADDR_W = 4;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam logic [3:0] REG_CMD  = 4'h8;
  localparam int CTRL_MON      = 0;
  localparam int CTRL_FRONT    = 1;
  localparam int CTRL_CROWBAR  = 2;
  localparam int CMD_INJECT    = 0;
  localparam int CMD_STYLE_LSB = 1;
  localparam int CMD_RELEASE   = 3;
  localparam int CMD_CLEAR     = 4;
  localparam int STAT_SEEN     = 0;
  localparam int STAT_STYLE    = 1;
  localparam int STAT_DRIVE    = 3;
  localparam int STAT_FLAGS    = 8;
  localparam logic [2:0] CTRL_RESET = 3'h0;

  typedef enum logic [1:0] {
    FSP_SEQ   = 2'h0,
    FSP_CRIT  = 2'h1,
    FSP_EMERG = 2'h2
  } fsp_style_t;

  typedef enum logic [1:0] {
    FSP_RUN  = 2'h0,
    FSP_SHUT = 2'h1,
    FSP_OFF  = 2'h3
  } fsp_state_t;
endpackage

// ==== rtl/fsp_link_if.sv ====
// Purpose: sync clock, open drain fault line and status lines
// Assumes: each end drives the fault line low only while its enable is high
// Notes:   the wired level is worked out here
interface fsp_link_if;
  import fsp_pkg::*;
  logic              sync_shutdown_clock;
  logic              dev_ok_out;
  logic              dev_ok_oe;
  logic              mgr_ok_out;
  logic              mgr_ok_oe;
  logic              ok_line;
  logic [FLAG_W-1:0] dev_flags;

  // wired and of both open drain drivers
  assign ok_line = ~((dev_ok_oe & ~dev_ok_out) | (mgr_ok_oe & ~mgr_ok_out));

  modport dev (input sync_shutdown_clock, input ok_line,
               output dev_ok_out, output dev_ok_oe, output dev_flags);
  modport mgr (output sync_shutdown_clock, input ok_line,
               output mgr_ok_out, output mgr_ok_oe, input dev_flags);
endinterface

// ==== rtl/fsp_mgr_end.sv ====
// Purpose: power manager end: sync clock, fault relay, status capture
// Assumes: software port with read data one cycle after the strobe
// Notes:   sync clock made by dividing clk
module fsp_mgr_end
  import fsp_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset,
  fsp_link_if.mgr                link,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [31:0]       wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [31:0]       rdata,
  input  wire logic              relay_req,
  input  wire fsp_style_t        relay_style,
  output logic                   relay_out,
  output fsp_style_t             relay_out_style,
  output logic                   front_end_off,
  output logic                   crowbar_fire
);
  typedef struct packed {
    logic [4:0]        div;
    logic              sd;
    logic              ok_m;
    logic              ok_s;
    logic [FLAG_W-1:0] fl_m;
    logic [FLAG_W-1:0] fl_s;
    logic [FLAG_W-1:0] flags;
    logic [2:0]        ctrl;
    logic              pend;
    logic [1:0]        tx_ph;
    logic              drive;
    fsp_style_t        tx_style;
    logic [1:0]        rx_ph;
    logic              rx_s1;
    logic              seen;
    fsp_style_t        seen_style;
    logic              relay;
    logic              rel;
    logic [31:0]       rdata;
  } fsp_mgr_t;

  fsp_mgr_t s_reg, s_next;
  logic     sd_fall, sd_rise, self_tx;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    s_next = s_reg;
    s_next.relay = 1'b0;
    s_next.rdata = 32'h0;
    sd_fall = 1'b0;
    sd_rise = 1'b0;
    // 500 kHz sync clock divider
    if (s_reg.div == 5'(SYNC_HALF_CYC - 1)) begin
      s_next.div = 5'h0;
      s_next.sd = ~s_reg.sd;
      sd_fall = s_reg.sd;
      sd_rise = ~s_reg.sd;
    end else begin
      s_next.div = s_reg.div + 5'h1;
    end
    s_next.ok_m = link.ok_line;
    s_next.ok_s = s_reg.ok_m;
    s_next.fl_m = link.dev_flags;
    s_next.fl_s = s_reg.fl_m;
    // status monitoring
    if (s_reg.ctrl[CTRL_MON]) begin
      s_next.flags = s_reg.fl_s;
    end
    // software port
    if (wr && addr == REG_CTRL) begin
      s_next.ctrl = wdata[2:0];
    end
    if (wr && addr == REG_CMD) begin
      if (wdata[CMD_INJECT]) begin
        s_next.pend = 1'b1;
        s_next.tx_style = fsp_style_t'(wdata[CMD_STYLE_LSB +: 2]);
      end
      if (wdata[CMD_CLEAR]) begin
        s_next.seen = 1'b0;
      end
      if (wdata[CMD_RELEASE]) begin
        s_next.rel = 1'b1;
      end
    end
    if (rd) begin
      unique case (addr)
        REG_CTRL: s_next.rdata = {29'h0, s_reg.ctrl};
        REG_STAT: s_next.rdata = {17'h0, s_reg.flags, 4'h0, s_reg.drive,
                                  s_reg.seen_style, s_reg.seen};
        default:  s_next.rdata = 32'h0;
      endcase
    end
    // relay code unchanged from another group
    if (relay_req) begin
      s_next.pend = 1'b1;
      s_next.tx_style = relay_style;
    end
    // fault line coding on sync falling edge
    if (sd_fall) begin
      if (s_reg.rel) begin
        s_next.drive = 1'b0;
        s_next.tx_ph = 2'h0;
        s_next.pend = 1'b0;
        s_next.rel = 1'b0;
      end else if (s_reg.pend) begin
        s_next.pend = 1'b0;
        s_next.drive = 1'b1;
        s_next.tx_ph = 2'h1;
      end else if (s_reg.tx_ph == 2'h1) begin
        s_next.drive = s_reg.tx_style == FSP_SEQ;
        s_next.tx_ph = 2'h2;
      end else if (s_reg.tx_ph == 2'h2) begin
        s_next.drive = s_reg.tx_style != FSP_EMERG;
        s_next.tx_ph = 2'h3;
      end else if (s_reg.tx_ph == 2'h3) begin
        s_next.drive = 1'b1;
      end
    end
    // decode a device's code on sync rising edges
    self_tx = s_reg.pend | s_reg.drive | (s_reg.tx_ph != 2'h0);
    if (sd_rise && !self_tx) begin
      unique case (s_reg.rx_ph)
        2'h0: if (!s_reg.ok_s) s_next.rx_ph = 2'h1;
        2'h1: begin
          s_next.rx_s1 = s_reg.ok_s;
          s_next.rx_ph = 2'h2;
        end
        2'h2: begin
          s_next.rx_ph = 2'h3;
          s_next.seen = 1'b1;
          s_next.relay = 1'b1;
          s_next.seen_style = !s_reg.rx_s1 ? FSP_SEQ :
                              s_reg.ok_s ? FSP_EMERG : FSP_CRIT;
        end
        2'h3: if (s_reg.ok_s) s_next.rx_ph = 2'h0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_reg <= '{div: 5'h0, sd: 1'b1, ok_m: 1'b1, ok_s: 1'b1,
                 fl_m: FLAGS_RESET, fl_s: FLAGS_RESET, flags: FLAGS_RESET,
                 ctrl: CTRL_RESET, pend: 1'b0, tx_ph: 2'h0, drive: 1'b0,
                 tx_style: FSP_SEQ, rx_ph: 2'h0, rx_s1: 1'b1, seen: 1'b0,
                 seen_style: FSP_SEQ, relay: 1'b0, rel: 1'b0,
                 rdata: 32'h0};
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign link.sync_shutdown_clock = s_reg.sd;
  assign link.mgr_ok_out = 1'b0;
  assign link.mgr_ok_oe  = s_reg.drive;
  assign rdata           = s_reg.rdata;
  assign relay_out       = s_reg.relay;
  assign relay_out_style = s_reg.seen_style;
  // front end and crowbar commands
  assign front_end_off = s_reg.seen & s_reg.ctrl[CTRL_FRONT];
  assign crowbar_fire  = s_reg.seen & s_reg.ctrl[CTRL_CROWBAR];
endmodule

// ==== rtl/fsp_dev_end.sv ====
// Purpose: regulator end: shutdown styles, fault line coding, pwm timing
// Assumes: fault inputs and config come from logic on clk
// Notes:   sync clock and fault line pass two flops first
// Notes on behaviour
// - sequenced style ramps down at programmed rate
// - critical style turns both switches off
// - emergency: high side off, low side on
// - style per heat, low, high fault configurable
// - propagating fault pulls shared fault line low
// - observed low line: shut down same style
// - style coded when line goes high to low
// - line changes only on sync falling edge
// - non-propagating fault: shut alone, flag, line high
// - non-latching retry every 130 ms, fixed
// - propagate only faults with enable set
// - manager relays code unchanged between groups
// - whole group applies the same shutdown
// - lock to 500 kHz sync, start on fall
// - switching 500 kHz or 1 MHz, per unit
// - start delayed by phase in 22.5 degree steps
// - manager reads status flags when monitoring
// - manager may cut front end, fire crowbar
// - protection event clears its flag bit to 0
// - latching fault stays off until its flags are cleared
module fsp_dev_end
  import fsp_pkg::*;
#(
  parameter int RETRY_CYCLES = RETRY_CYC
)
(
  input  wire logic               clk,
  input  wire logic               reset,
  fsp_link_if.dev                 link,
  input  wire logic               heat_warning,
  input  wire logic               power_good,
  input  wire logic               ramp_follow_fault,
  input  wire logic               die_heat_fault,
  input  wire logic               current_limit_fault,
  input  wire logic               output_low_fault,
  input  wire logic               output_high_limit,
  input  wire logic               heat_style_crit,
  input  wire logic               low_style_crit,
  input  wire logic               high_style_emerg,
  input  wire logic [4:0]         propagation_config_reg,
  input  wire logic [4:0]         latch_config,
  input  wire logic               flags_clear,
  input  wire logic               fast_switching,
  input  wire logic [PHASE_W-1:0] phase_sel,
  input  wire logic               ramp_done,
  output logic                    high_side_en,
  output logic                    low_side_en,
  output logic                    ramp_down_req,
  output logic                    pwm_start,
  output logic                    running,
  output logic [FLAG_W-1:0]       protection_flags_reg
);
  typedef struct packed {
    logic              sd_m;
    logic              sd_s;
    logic              sd_d;
    logic              ok_m;
    logic              ok_s;
    fsp_state_t        state;
    fsp_style_t        style;
    logic              ext;
    logic              latched;
    logic [RETRY_W-1:0] retry;
    logic [FLAG_W-1:0] flags;
    logic              pend;
    logic [1:0]        tx_ph;
    logic              drive;
    logic [1:0]        rx_ph;
    logic              rx_s1;
    logic [CNT_W-1:0]  period;
    logic [CNT_W-1:0]  pcnt;
    logic              start;
    logic              hs;
    logic              ls;
  } fsp_dev_t;

  fsp_dev_t             s_reg, s_next;
  logic                 sd_fall, sd_rise, self_tx, any_fault, prop, latch;
  logic                 rx_hit;
  fsp_style_t           own_style, rx_style;
  logic [4:0]           faults;
  logic [CNT_W+PHASE_W-1:0] prod;
  logic [CNT_W-1:0]     delay, second;

  // ****************************************************************
  // fault classification
  // ****************************************************************
  always_comb begin
    faults = {output_high_limit, output_low_fault, current_limit_fault,
              die_heat_fault, ramp_follow_fault};
    any_fault = |faults;
    prop  = |(faults & propagation_config_reg);
    latch = |(faults & latch_config);
    // most severe active style wins
    own_style = FSP_SEQ;
    if ((die_heat_fault && heat_style_crit) ||
        (output_low_fault && low_style_crit) ||
        ramp_follow_fault || current_limit_fault) begin
      own_style = FSP_CRIT;
    end
    if (output_high_limit) begin
      own_style = high_style_emerg ? FSP_EMERG : FSP_CRIT;
    end
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    s_next = s_reg;
    s_next.sd_m = link.sync_shutdown_clock;
    s_next.sd_s = s_reg.sd_m;
    s_next.sd_d = s_reg.sd_s;
    s_next.ok_m = link.ok_line;
    s_next.ok_s = s_reg.ok_m;
    sd_fall = s_reg.sd_d & ~s_reg.sd_s;
    sd_rise = ~s_reg.sd_d & s_reg.sd_s;
    s_next.start = 1'b0;
    rx_hit = 1'b0;
    rx_style = FSP_SEQ;

    // flags: live warnings, sticky fault bits, a fault wins over flags_clear
    s_next.flags[FLAG_HEAT_WARN] = ~heat_warning;
    s_next.flags[FLAG_PWR_GOOD]  = power_good;
    if (flags_clear) begin
      s_next.flags[6:2] = 5'h1F;
    end
    s_next.flags[6:2] = s_next.flags[6:2] & ~faults;

    // receive a peer's code on sync rising edges
    self_tx = s_reg.pend | s_reg.drive | (s_reg.tx_ph != 2'h0);
    if (sd_rise && !self_tx) begin
      unique case (s_reg.rx_ph)
        2'h0: if (!s_reg.ok_s) s_next.rx_ph = 2'h1;
        2'h1: begin
          s_next.rx_s1 = s_reg.ok_s;
          s_next.rx_ph = 2'h2;
        end
        2'h2: begin
          s_next.rx_ph = 2'h3;
          rx_hit = 1'b1;
          rx_style = !s_reg.rx_s1 ? FSP_SEQ :
                     s_reg.ok_s ? FSP_EMERG : FSP_CRIT;
        end
        2'h3: if (s_reg.ok_s) s_next.rx_ph = 2'h0;
      endcase
    end

    // shutdown state machine
    unique case (s_reg.state)
      FSP_RUN: begin
        if (any_fault || rx_hit) begin
          s_next.style   = any_fault ? own_style : rx_style;
          s_next.ext     = ~any_fault;
          s_next.latched = any_fault & latch;
          s_next.pend    = any_fault & prop;
          // timer loaded at the fault, counts down only in FSP_OFF, so after ramp down for sequenced style
          s_next.retry   = RETRY_W'(RETRY_CYCLES - 1);
          unique case (s_next.style)
            FSP_SEQ: s_next.state = FSP_SHUT;
            FSP_CRIT: begin
              s_next.hs = 1'b0;
              s_next.ls = 1'b0;
              s_next.state = FSP_OFF;
            end
            default: begin
              s_next.hs = 1'b0;
              s_next.ls = 1'b1;
              s_next.state = FSP_OFF;
            end
          endcase
        end
      end
      FSP_SHUT: begin
        if (ramp_done) begin
          s_next.hs = 1'b0;
          s_next.ls = 1'b0;
          s_next.state = FSP_OFF;
        end
      end
      default: begin
        if (s_reg.retry != '0) begin
          s_next.retry = s_reg.retry - RETRY_W'(1);
        end
        if (s_reg.ext) begin
          // group follower restarts once line is free
          if (s_reg.ok_s && s_reg.rx_ph == 2'h0 && s_reg.state != FSP_SHUT) begin
            s_next.state = FSP_RUN;
          end
        end else if (s_reg.retry == '0) begin
          if (!any_fault && (!s_reg.latched || &s_reg.flags[6:2])) begin
            s_next.state = FSP_RUN;
          end else if (!s_reg.latched) begin
            s_next.retry = RETRY_W'(RETRY_CYCLES - 1);
          end
        end
        if (s_next.state == FSP_RUN) begin
          s_next.hs = 1'b1;
          s_next.ls = 1'b1;
        end
      end
    endcase
    if (s_reg.state == FSP_SHUT && s_reg.ext && ramp_done) begin
      s_next.state = FSP_OFF;
    end

    // fault line coding, only on sync falling edge
    if (sd_fall) begin
      if (s_reg.state == FSP_RUN && !s_reg.pend) begin
        s_next.drive = 1'b0;
        s_next.tx_ph = 2'h0;
      end else if (s_reg.pend) begin
        s_next.pend = 1'b0;
        s_next.drive = 1'b1;
        s_next.tx_ph = 2'h1;
      end else if (s_reg.tx_ph == 2'h1) begin
        s_next.drive = s_reg.style == FSP_SEQ;
        s_next.tx_ph = 2'h2;
      end else if (s_reg.tx_ph == 2'h2) begin
        s_next.drive = s_reg.style != FSP_EMERG;
        s_next.tx_ph = 2'h3;
      end else if (s_reg.tx_ph == 2'h3) begin
        s_next.drive = 1'b1;
      end
    end

    // period tracking of sync clock
    if (sd_fall) begin
      s_next.period = s_reg.pcnt + CNT_W'(1);
      s_next.pcnt = '0;
    end else if (s_reg.pcnt != '1) begin
      s_next.pcnt = s_reg.pcnt + CNT_W'(1);
    end
    // phase delayed switching starts
    prod = CNT_W'(s_reg.period) * (CNT_W + PHASE_W)'(phase_sel);
    delay = prod[CNT_W+PHASE_W-1:PHASE_W];
    second = delay + (s_reg.period >> 1);
    if (second >= s_reg.period) begin
      second = second - s_reg.period;
    end
    s_next.start = (s_reg.state == FSP_RUN) && (s_reg.period != '0) &&
                   (s_reg.pcnt == delay ||
                    (fast_switching && s_reg.pcnt == second));
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_reg <= '{sd_m: 1'b1, sd_s: 1'b1, sd_d: 1'b1, ok_m: 1'b1,
                 ok_s: 1'b1, state: FSP_RUN, style: FSP_SEQ, ext: 1'b0,
                 latched: 1'b0, retry: '0, flags: FLAGS_RESET,
                 pend: 1'b0, tx_ph: 2'h0, drive: 1'b0, rx_ph: 2'h0,
                 rx_s1: 1'b1, period: '0, pcnt: '0, start: 1'b0,
                 hs: 1'b1, ls: 1'b1};
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign link.dev_ok_out      = 1'b0;
  assign link.dev_ok_oe       = s_reg.drive;
  assign link.dev_flags       = s_reg.flags;
  assign high_side_en         = s_reg.hs;
  assign low_side_en          = s_reg.ls;
  assign ramp_down_req        = s_reg.state == FSP_SHUT;
  assign pwm_start            = s_reg.start;
  assign running              = s_reg.state == FSP_RUN;
  assign protection_flags_reg = s_reg.flags;
endmodule

// ==== sim/fsp_link_checker.sv ====
// Purpose: assertions on the fault shutdown link wires
// Assumes: one clock domain, reset active high
// Notes:   placed beside the link interface
module fsp_link_checker
  import fsp_pkg::*;
(
  input wire logic              clk,
  input wire logic              reset,
  input wire logic              sync_shutdown_clock,
  input wire logic              dev_ok_out,
  input wire logic              dev_ok_oe,
  input wire logic              mgr_ok_out,
  input wire logic              mgr_ok_oe,
  input wire logic              ok_line,
  input wire logic [FLAG_W-1:0] dev_flags
);
  timeunit 1ns;
  timeprecision 1ns;
  // ********
  // helpers
  // ********
  logic [7:0] run_reg, age_reg, doe_reg, moe_reg;
  logic       sd_reg, seen_reg;
  function automatic logic [7:0] inc(input logic [7:0] v);
    return v + {7'h0, v != 8'hFF};
  endfunction
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      run_reg  <= 8'h00;
      age_reg  <= 8'hFF;
      doe_reg  <= 8'h00;
      moe_reg  <= 8'h00;
      sd_reg   <= 1'b1;
      seen_reg <= 1'b0;
    end else begin
      sd_reg   <= sync_shutdown_clock;
      seen_reg <= seen_reg | (sync_shutdown_clock != sd_reg);
      run_reg  <= (sync_shutdown_clock != sd_reg) ? 8'h01 : inc(run_reg);
      age_reg  <= (sd_reg & !sync_shutdown_clock) ? 8'h00 : inc(age_reg);
      doe_reg  <= dev_ok_oe ? inc(doe_reg) : 8'h00;
      moe_reg  <= mgr_ok_oe ? inc(moe_reg) : 8'h00;
    end
  end
  // ********
  // assertions
  // ********
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_sync_half: assert property (
    seen_reg && $changed(sync_shutdown_clock) |-> run_reg == SYNC_HALF_CYC)
    else $error("sync half period wrong");
  a_sync_alive: assert property (
    seen_reg |-> run_reg <= SYNC_HALF_CYC)
    else $error("sync clock stalled");
  a_dev_line_edge: assert property (
    $changed(dev_ok_oe) |-> !sync_shutdown_clock && age_reg <= 8'd6)
    else $error("device line change off sync fall");
  a_mgr_line_edge: assert property (
    $changed(mgr_ok_oe) |-> $fell(sync_shutdown_clock) || age_reg <= 8'd4)
    else $error("manager line change off sync fall");
  a_open_drain: assert property (
    !dev_ok_out && !mgr_ok_out)
    else $error("fault line driven high");
  a_dev_phase_len: assert property (
    $fell(dev_ok_oe) |-> doe_reg >= 8'd38)
    else $error("device code phase too short");
  a_mgr_phase_len: assert property (
    $fell(mgr_ok_oe) |-> moe_reg >= 8'd38)
    else $error("manager code phase too short");
  a_flag_first: assert property (
    $rose(dev_ok_oe) |-> dev_flags != FLAGS_RESET)
    else $error("line pulled with no flag cleared");
  c_dev_code: cover property ($rose(dev_ok_oe));
  c_mgr_code: cover property ($rose(mgr_ok_oe));
  c_line_fall: cover property ($fell(ok_line));
endmodule

// ==== sim/test_fault_shutdown_propagation.sv ====
// Purpose: bench for both ends of the fault shutdown link
// Assumes: retry count cut to 200 cycles
// Notes:   table cases first, hand-written cases after
module test_fault_shutdown_propagation
  import fsp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [4:0] f;
    logic [2:0] cfg;
    fsp_style_t s;
    logic [1:0] sw;
    logic       rr;
  } fsp_row_t;
  // fault {high,low,cur,heat,ramp}, cfg {heat,low,high}
  localparam fsp_row_t ROWS [8] = '{
    '{5'h08, 3'h0, FSP_SEQ, 2'h0, 1'b1}, '{5'h08, 3'h2, FSP_CRIT, 2'h0, 1'b0},
    '{5'h02, 3'h0, FSP_SEQ, 2'h0, 1'b1}, '{5'h02, 3'h4, FSP_CRIT, 2'h0, 1'b0},
    '{5'h10, 3'h1, FSP_EMERG, 2'h1, 1'b0}, '{5'h10, 3'h0, FSP_CRIT, 2'h0, 1'b0},
    '{5'h04, 3'h0, FSP_CRIT, 2'h0, 1'b0}, '{5'h01, 3'h0, FSP_CRIT, 2'h0, 1'b0}};
  logic        clk, reset, wr, rd, relay_req, flags_clear, ramp_done;
  logic        heat_style_crit, low_style_crit, high_style_emerg;
  logic        fast_switching, relay_out, front_end_off, crowbar_fire;
  logic        high_side_en, low_side_en, ramp_down_req, pwm_start, running;
  logic [3:0]  addr, phase_sel;
  logic [4:0]  fault, propagation_config_reg, latch_config;
  logic [6:0]  protection_flags_reg;
  logic [31:0] wdata, rdata, d;
  fsp_style_t  relay_style, relay_out_style;
  fsp_row_t    r;
  int          num_errors, cmp_count, g0, g1, g2, g3;

  fsp_link_if link();
  fsp_mgr_end fsp_mgr_end_inst (.clk, .reset, .link, .addr, .wdata, .wr,
    .rd, .rdata, .relay_req, .relay_style, .relay_out, .relay_out_style,
    .front_end_off, .crowbar_fire);
  fsp_dev_end #(.RETRY_CYCLES(200)) fsp_dev_end_inst (.clk, .reset, .link,
    .heat_warning(1'b0), .power_good(1'b1), .ramp_follow_fault(fault[0]),
    .die_heat_fault(fault[1]), .current_limit_fault(fault[2]),
    .output_low_fault(fault[3]), .output_high_limit(fault[4]),
    .heat_style_crit, .low_style_crit, .high_style_emerg,
    .propagation_config_reg, .latch_config, .flags_clear, .fast_switching,
    .phase_sel, .ramp_done, .high_side_en, .low_side_en, .ramp_down_req,
    .pwm_start, .running, .protection_flags_reg);
  fsp_link_checker fsp_link_checker_inst (.clk, .reset,
    .sync_shutdown_clock(link.sync_shutdown_clock),
    .dev_ok_out(link.dev_ok_out), .dev_ok_oe(link.dev_ok_oe),
    .mgr_ok_out(link.mgr_ok_out), .mgr_ok_oe(link.mgr_ok_oe),
    .ok_line(link.ok_line), .dev_flags(link.dev_flags));

  always #25 clk = ~clk;

  // ********
  // tasks
  // ********
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic bus_wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic bus_rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask
  task automatic pulse_clear();
    flags_clear <= 1'b1;
    wait_clk(1);
    flags_clear <= 1'b0;
    wait_clk(1);
  endtask
  task automatic code_chk(input fsp_style_t s);
    int n;
    n = 0;
    while (link.ok_line !== 1'b0 && n < 400) begin
      @(posedge clk);
      n++;
    end
    @(posedge link.sync_shutdown_clock);
    check(link.ok_line, 1'b0);
    @(posedge link.sync_shutdown_clock);
    check(link.ok_line, s != FSP_SEQ);
    @(posedge link.sync_shutdown_clock);
    check(link.ok_line, s == FSP_EMERG);
  endtask
  task automatic gap(output int t0, output int t1);
    t0 = 0;
    t1 = 0;
    @(negedge link.sync_shutdown_clock);
    for (int n = 1; n < 100; n++) begin
      @(negedge clk);
      if (pwm_start === 1'b1 && t0 == 0) t0 = n;
      else if (pwm_start === 1'b1 && t1 == 0) t1 = n;
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    wait_clk(30000);
    num_errors++;
    print_verdict();
  end

  // ********
  // main sequence
  // ********
  initial begin
    clk = 1'b0;
    reset = 1'b1;
    {wr, rd, relay_req, flags_clear, ramp_done, fast_switching} = '0;
    {heat_style_crit, low_style_crit, high_style_emerg} = '0;
    {addr, phase_sel, fault, latch_config, wdata} = '0;
    propagation_config_reg = 5'h1F;
    relay_style = FSP_SEQ;
    wait_clk(5);
    reset <= 1'b0;
    bus_wr(REG_CTRL, 32'h7);
    bus_rd(REG_CTRL, d);
    check(d[2:0], 3'h7);
    foreach (ROWS[i]) begin
      r = ROWS[i];
      {heat_style_crit, low_style_crit, high_style_emerg} <= r.cfg;
      ramp_done <= 1'b0;
      wait_clk(2);
      fault <= r.f;
      code_chk(r.s);
      check(ramp_down_req, r.rr);
      bus_rd(REG_STAT, d);
      check({d[14:8], d[3:0]},
            {FLAGS_RESET & ~{r.f, 2'h0}, 1'b0, r.s, 1'b1});
      check({relay_out_style, front_end_off, crowbar_fire},
            {r.s, 2'h3});
      ramp_done <= 1'b1;
      wait_clk(4);
      check({high_side_en, low_side_en, running}, {r.sw, 1'b0});
      fault <= 5'h00;
      wait_clk(500);
      check({running, link.ok_line}, 2'h3);
      bus_wr(REG_CMD, 32'h10);
      pulse_clear();
      $display("table row %0d done", i);
    end
    low_style_crit <= 1'b1;
    propagation_config_reg <= 5'h00;
    fault <= 5'h08;
    wait_clk(1);
    fault <= 5'h00;
    wait_clk(150);
    check({link.ok_line, running, protection_flags_reg}, 9'h15F);
    bus_rd(REG_STAT, d);
    check(d[0], 1'b0);
    wait_clk(100);
    check(running, 1'b1);
    pulse_clear();
    $display("silent fault and retry done");
    latch_config <= 5'h08;
    fault <= 5'h08;
    wait_clk(1);
    fault <= 5'h00;
    wait_clk(300);
    check(running, 1'b0);
    pulse_clear();
    wait_clk(450);
    check(running, 1'b1);
    latch_config <= 5'h00;
    propagation_config_reg <= 5'h1F;
    $display("latched fault done");
    for (int s = 0; s < 3; s++) begin
      ramp_done <= 1'b0;
      bus_wr(REG_CMD, s * 2 + 1);
      wait_clk(240);
      check(ramp_down_req, s == 0);
      ramp_done <= 1'b1;
      wait_clk(4);
      check({high_side_en, low_side_en}, {1'b0, s == 2});
      bus_wr(REG_CMD, 32'h8);
      wait_clk(200);
      check(running, 1'b1);
    end
    $display("peer shutdown done");
    gap(g0, g1);
    check(g1 - g0, 40);
    phase_sel <= 4'h8;
    wait_clk(100);
    gap(g2, g3);
    check(g2 - g0, 20);
    phase_sel <= 4'h0;
    fast_switching <= 1'b1;
    wait_clk(100);
    gap(g2, g3);
    check(g3 - g2, 20);
    $display("switching timing done");
    reset <= 1'b1;
    wait_clk(2);
    check({link.dev_ok_oe, protection_flags_reg}, FLAGS_RESET);
    reset <= 1'b0;
    bus_rd(REG_CTRL, d);
    check(d[2:0], CTRL_RESET);
    bus_rd(4'hC, d);
    check(d, 32'h0);
    $display("reset and port done");
    print_verdict();
  end
endmodule
